// ---- design/spbrt_pkg.sv ----
// Package: constants for the segmented packet bus receive sideband and transmit ready block
package spbrt_pkg;
  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned SPBRT_NUM_SEG    = 4;
  localparam int unsigned SPBRT_MTY_W     = 4;
  localparam int unsigned SPBRT_MTY_LOW_W = 3;
  localparam int unsigned SPBRT_MTY_MSB   = 3;
  // ****************************************************************
  // Reset values and transmit allowance
  // ****************************************************************
  localparam logic [2:0] SPBRT_MTY_LOW_CLR = 3'h0;
  localparam logic [3:0] SPBRT_MTY_RST     = 4'h0;
  localparam int unsigned SPBRT_TX_SLACK   = 4;
  localparam int unsigned SPBRT_CNT_W      = 8;
  localparam logic [7:0] SPBRT_CNT_ONE     = 8'h01;
  localparam logic [7:0] SPBRT_CNT_ZERO    = 8'h00;
  // Transmit overflow tracker states
  typedef enum logic [1:0] {SPBRT_TX_OK, SPBRT_TX_STALL, SPBRT_TX_OVF} spbrt_tx_state_t;
endpackage : spbrt_pkg

// ---- design/spbrt_seg.sv ----
// One receive segment: registered sideband outputs with error masking of the empty count
`timescale 1ns/1ps
`default_nettype none
module spbrt_seg
  import spbrt_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   clk_en,
  // Core side
  input  wire logic                   in_ena,
  input  wire logic                   in_sop,
  input  wire logic                   in_eop,
  input  wire logic                   in_err,
  input  wire logic [SPBRT_MTY_W-1:0] in_mty,
  // User side
  output logic                        ena_q,
  output logic                        sop_q,
  output logic                        eop_q,
  output logic                        err_q,
  output logic [SPBRT_MTY_W-1:0]      mty_q
);
  // ****************************************************************
  // Empty count masking
  // ****************************************************************
  // Low bits cleared on an errored transfer; top bit passes through
  logic                   err_d;
  logic [SPBRT_MTY_W-1:0] mty_d;
  assign err_d = in_ena & in_err;
  assign mty_d = err_d ? {in_mty[SPBRT_MTY_MSB], SPBRT_MTY_LOW_CLR} : in_mty;

  // Sideband registers; sop/eop only flagged with enable so idle cycles read clean
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ena_q <= 1'b0;
      sop_q <= 1'b0;
      eop_q <= 1'b0;
      err_q <= 1'b0;
      mty_q <= SPBRT_MTY_RST;
    end
    else if (clk_en)
    begin
      ena_q <= in_ena;
      sop_q <= in_ena & in_sop;
      eop_q <= in_ena & in_eop;
      err_q <= err_d;
      mty_q <= mty_d;
    end
  end
endmodule : spbrt_seg
`default_nettype wire

// ---- design/spbrt_top.sv ----
// Top: four receive segments and transmit ready with overflow detection
`timescale 1ns/1ps
`default_nettype none
module spbrt_top
  import spbrt_pkg::*;
#(
  parameter int unsigned NUM_SEG  = SPBRT_NUM_SEG,
  parameter int unsigned TX_SLACK = SPBRT_TX_SLACK
)
(
  // Clock, reset, enable
  input  wire logic                           sys_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           clk_en,
  // Receive side from the core datapath
  input  wire logic [NUM_SEG-1:0]             rx_ena_in,
  input  wire logic [NUM_SEG-1:0]             rx_sop_in,
  input  wire logic [NUM_SEG-1:0]             rx_eop_in,
  input  wire logic [NUM_SEG-1:0]             rx_err_in,
  input  wire logic [NUM_SEG*SPBRT_MTY_W-1:0] rx_mty_in,
  // Receive sideband toward user logic
  output logic [NUM_SEG-1:0]                  rx_ena_q,
  output logic [NUM_SEG-1:0]                  rx_sop_q,
  output logic [NUM_SEG-1:0]                  rx_eop_q,
  output logic [NUM_SEG-1:0]                  rx_err_q,
  output logic [NUM_SEG*SPBRT_MTY_W-1:0]      rx_mty_q,
  // Transmit side
  input  wire logic                           tx_can_accept,
  input  wire logic [NUM_SEG-1:0]             tx_ena_in,
  output logic                                tx_rdy_q,
  output logic                                tx_ovf_q
);
  // ****************************************************************
  // Receive segments
  // ****************************************************************
  // One instance per segment keeps lanes independent
  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++)
    begin : g_seg
      spbrt_seg spbrt_seg_i (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .in_ena  (rx_ena_in[g]),
        .in_sop  (rx_sop_in[g]),
        .in_eop  (rx_eop_in[g]),
        .in_err  (rx_err_in[g]),
        .in_mty  (rx_mty_in[g*SPBRT_MTY_W +: SPBRT_MTY_W]),
        .ena_q   (rx_ena_q[g]),
        .sop_q   (rx_sop_q[g]),
        .eop_q   (rx_eop_q[g]),
        .err_q   (rx_err_q[g]),
        .mty_q   (rx_mty_q[g*SPBRT_MTY_W +: SPBRT_MTY_W])
      );
    end
  endgenerate

  // ****************************************************************
  // Transmit ready and overflow
  // ****************************************************************
  // Cycles of transfers seen since ready dropped; past slack is overflow
  spbrt_tx_state_t        st_q;
  spbrt_tx_state_t        st_d;
  logic [SPBRT_CNT_W-1:0] cnt_q;
  logic [SPBRT_CNT_W-1:0] cnt_d;
  logic                   tx_any;
  logic                   over;
  assign tx_any = |tx_ena_in;
  assign over   = tx_any && (cnt_q >= SPBRT_CNT_W'(TX_SLACK));

  // Overflow is sticky until reset: the path must be reset to recover
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      SPBRT_TX_OK:
      begin
        cnt_d = SPBRT_CNT_ZERO;
        if (!tx_rdy_q)
          st_d = SPBRT_TX_STALL;
      end
      SPBRT_TX_STALL:
      begin
        if (over)
          st_d = SPBRT_TX_OVF;
        else if (tx_rdy_q)
          st_d = SPBRT_TX_OK;
        else if (tx_any)
          cnt_d = cnt_q + SPBRT_CNT_ONE;
      end
      SPBRT_TX_OVF:
        st_d = SPBRT_TX_OVF;
      default:
        st_d = SPBRT_TX_OVF;
    endcase
  end

  // Ready registered from the core's accept level; held low after overflow
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q     <= SPBRT_TX_OK;
      cnt_q    <= SPBRT_CNT_ZERO;
      tx_rdy_q <= 1'b0;
      tx_ovf_q <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      tx_rdy_q <= tx_can_accept && (st_d != SPBRT_TX_OVF);
      tx_ovf_q <= (st_d == SPBRT_TX_OVF);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Low empty-count bits of one lane; shared by the masking checks
  function automatic logic [SPBRT_MTY_LOW_W-1:0] lane_mty_low(input logic [NUM_SEG*SPBRT_MTY_W-1:0] bus,
                                                              input int unsigned                      idx);
    return bus[idx*SPBRT_MTY_W +: SPBRT_MTY_LOW_W];
  endfunction : lane_mty_low

  property p_sop_needs_ena;
    @(posedge sys_clk) disable iff (sys_rst) rx_sop_q[0] |-> rx_ena_q[0];
  endproperty
  a_sop_needs_ena: assert property (p_sop_needs_ena) else $error("sop without enable");

  property p_eop_follows;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && rx_ena_in[1] && rx_eop_in[1]) |=> rx_eop_q[1];
  endproperty
  a_eop_follows: assert property (p_eop_follows) else $error("eop not passed");

  property p_err_follows;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en |=> (rx_err_q[2] == $past(rx_ena_in[2] & rx_err_in[2]));
  endproperty
  a_err_follows: assert property (p_err_follows) else $error("error flag wrong");

  property p_mty_mask;
    @(posedge sys_clk) disable iff (sys_rst)
      (rx_err_q[0] && rx_ena_q[0]) |-> (lane_mty_low(rx_mty_q, 0) == SPBRT_MTY_LOW_CLR);
  endproperty
  a_mty_mask: assert property (p_mty_mask) else $error("empty low bits not cleared");

  property p_mty_pass;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && !rx_err_in[3]) |=> (rx_mty_q[15:12] == $past(rx_mty_in[15:12]));
  endproperty
  a_mty_pass: assert property (p_mty_pass) else $error("empty count not passed");

  property p_ena_follows;
    @(posedge sys_clk) disable iff (sys_rst) clk_en |=> (rx_ena_q == $past(rx_ena_in));
  endproperty
  a_ena_follows: assert property (p_ena_follows) else $error("enable not registered");

  property p_rdy_follows;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && !tx_ovf_q && !over) |=> (tx_rdy_q == $past(tx_can_accept));
  endproperty
  a_rdy_follows: assert property (p_rdy_follows) else $error("ready wrong");

  property p_ovf_sticky;
    @(posedge sys_clk) disable iff (sys_rst) tx_ovf_q |=> (tx_ovf_q && !tx_rdy_q);
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow not sticky");

  property p_ovf_raise;
    @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && st_q == SPBRT_TX_STALL && over) |=> tx_ovf_q;
  endproperty
  a_ovf_raise: assert property (p_ovf_raise) else $error("overflow missed");

  // ****************************************************************
  // Per-lane sideband checks
  // ****************************************************************
  // Every lane gets the same checks; a wiring slip in one lane would hide from the single-lane ones
  genvar a;
  generate
    for (a = 0; a < NUM_SEG; a++)
    begin : g_chk
      property p_flags_gated;
        @(posedge sys_clk) disable iff (sys_rst)
          (rx_sop_q[a] || rx_eop_q[a] || rx_err_q[a]) |-> rx_ena_q[a];
      endproperty
      a_flags_gated: assert property (p_flags_gated) else $error("lane flag without enable");

      property p_lane_mask;
        @(posedge sys_clk) disable iff (sys_rst)
          (rx_err_q[a] && rx_ena_q[a]) |-> (lane_mty_low(rx_mty_q, a) == SPBRT_MTY_LOW_CLR);
      endproperty
      a_lane_mask: assert property (p_lane_mask) else $error("lane empty low bits not cleared");

      property p_lane_sop;
        @(posedge sys_clk) disable iff (sys_rst)
          clk_en |=> (rx_sop_q[a] == $past(rx_ena_in[a] && rx_sop_in[a]));
      endproperty
      a_lane_sop: assert property (p_lane_sop) else $error("lane start flag wrong");

      property p_lane_pass;
        @(posedge sys_clk) disable iff (sys_rst)
          (clk_en && !(rx_ena_in[a] && rx_err_in[a])) |=>
            (rx_mty_q[a*SPBRT_MTY_W +: SPBRT_MTY_W] == $past(rx_mty_in[a*SPBRT_MTY_W +: SPBRT_MTY_W]));
      endproperty
      a_lane_pass: assert property (p_lane_pass) else $error("lane empty count not passed");
    end
  endgenerate

  c_sop_eop: cover property (@(posedge sys_clk) disable iff (sys_rst) rx_sop_q[0] && rx_eop_q[0]);
  c_err_mty: cover property (@(posedge sys_clk) disable iff (sys_rst) rx_err_q[1] && rx_mty_q[7]);
  c_ovf:     cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(tx_ovf_q));
  c_recover: cover property (@(posedge sys_clk) disable iff (sys_rst) st_q == SPBRT_TX_STALL ##1 st_q == SPBRT_TX_OK);
endmodule : spbrt_top
`default_nettype wire

// ---- sim/spbrt_user_model.sv ----
// User transmit logic model that reacts to ready with a bounded stop lag
`timescale 1ns/1ps
`default_nettype none
module spbrt_user_model
#(
  parameter int unsigned LAG = 1
)
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Bench control: ignore back-pressure
  input  wire logic       greedy,
  // Transmit handshake
  input  wire logic       tx_rdy_q,
  output logic      [3:0] tx_ena_in
);
  logic [7:0] lag_q;
  // Lag counter saturates so a long stall never wraps into sending again
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lag_q     <= 8'h00;
      tx_ena_in <= 4'h0;
    end
    else
    begin
      lag_q     <= (tx_rdy_q || lag_q == 8'hff) ? (tx_rdy_q ? 8'h00 : lag_q) : lag_q + 8'h01;
      tx_ena_in <= (greedy || tx_rdy_q || lag_q < 8'(LAG)) ? 4'hf : 4'h0;
    end
  end
endmodule : spbrt_user_model
`default_nettype wire

// ---- sim/spbrt_top_tb.sv ----
// Testbench: random receive sideband traffic and transmit back-pressure checks
`timescale 1ns/1ps
`default_nettype none
module spbrt_top_tb;
  import spbrt_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en  = 1'b1;
  logic [3:0]  ena_in  = 4'h0, sop_in = 4'h0, eop_in = 4'h0, err_in = 4'h0;
  logic [15:0] mty_in  = 16'h0;
  logic        can_acc = 1'b0;
  logic        greedy  = 1'b0;
  logic [3:0]  ena_q, sop_q, eop_q, err_q, tx_ena;
  logic [15:0] mty_q;
  logic        rdy_q, ovf_q;
  logic [32:0] exp_q[$];
  logic [32:0] last_exp = 33'h0;
  logic [32:0] mon_e;
  logic [31:0] seed = 32'h000130d5;
  int          num_errors = 0;
  int          check_count = 0;
  int          n;
  // Small allowance so the overflow case stays short
  spbrt_top #(.NUM_SEG(4), .TX_SLACK(2)) spbrt_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .rx_ena_in(ena_in), .rx_sop_in(sop_in), .rx_eop_in(eop_in),
    .rx_err_in(err_in), .rx_mty_in(mty_in), .rx_ena_q(ena_q), .rx_sop_q(sop_q),
    .rx_eop_q(eop_q), .rx_err_q(err_q), .rx_mty_q(mty_q), .tx_can_accept(can_acc),
    .tx_ena_in(tx_ena), .tx_rdy_q(rdy_q), .tx_ovf_q(ovf_q));
  spbrt_user_model #(.LAG(1)) spbrt_user_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .greedy(greedy), .tx_rdy_q(rdy_q), .tx_ena_in(tx_ena));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  always #25 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Random traffic at the falling edge; a frozen edge expects held outputs
  task automatic drive_rx(input int cnt);
    logic [15:0] mm;
    repeat (cnt)
    begin
      @(negedge sys_clk);
      seed = xs(seed);
      {ena_in, sop_in, eop_in, err_in, mty_in} = seed;
      seed = xs(seed);
      clk_en  = seed[3:0] != 4'h0;
      can_acc = seed[6:4] != 3'h0;
      for (int g = 0; g < 4; g++)
        mm[4*g +: 4] = (ena_in[g] & err_in[g]) ? {mty_in[4*g+3], 3'h0} : mty_in[4*g +: 4];
      if (clk_en)
        last_exp = {can_acc, ena_in, ena_in & sop_in, ena_in & eop_in, ena_in & err_in, mm};
      exp_q.push_back(last_exp);
    end
  endtask : drive_rx
  // ****************************************************************
  // Monitor: oldest note against the settled outputs
  // ****************************************************************
  always @(posedge sys_clk)
  begin
    #1;
    if (exp_q.size() > 0)
    begin
      mon_e = exp_q.pop_front();
      check("rx_ena", 16'(ena_q), 16'(mon_e[31:28]));
      check("rx_sop", 16'(sop_q), 16'(mon_e[27:24]));
      check("rx_eop", 16'(eop_q), 16'(mon_e[23:20]));
      check("rx_err", 16'(err_q), 16'(mon_e[19:16]));
      check("rx_mty", mty_q, mon_e[15:0]);
      check("tx_rdy", 16'(rdy_q), 16'(mon_e[32]));
      check("tx_ovf", 16'(ovf_q), 16'h0);
      // User side reads error and empty count only on an enabled end
      for (int g = 0; g < 4; g++)
        if (mon_e[28+g] && mon_e[20+g])
        begin
          check("rx_err_end", 16'(err_q[g]), 16'(mon_e[16+g]));
          check("rx_mty_end", 16'(mty_q[4*g +: 4]), 16'(mon_e[4*g +: 4]));
        end
    end
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    num_errors++;
    stop_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    drive_rx(300);
    // Ignore back-pressure: overflow must rise and stay
    @(negedge sys_clk);
    clk_en  = 1'b1;
    can_acc = 1'b0;
    greedy  = 1'b1;
    n = 0;
    while (ovf_q !== 1'b1 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    check("tx_ovf_set", 16'(ovf_q), 16'h1);
    can_acc = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("tx_rdy_sticky", 16'(rdy_q), 16'h0);
    check("tx_ovf_sticky", 16'(ovf_q), 16'h1);
    // Reset recovers the transmit path
    sys_rst  = 1'b1;
    greedy   = 1'b0;
    // Frozen across release so stale inputs never reach the outputs unnoted
    clk_en   = 1'b0;
    last_exp = 33'h0;
    @(negedge sys_clk);
    check("tx_ovf_rst", 16'(ovf_q), 16'h0);
    sys_rst = 1'b0;
    drive_rx(200);
    repeat (2) @(negedge sys_clk);
    stop_test();
  end
endmodule : spbrt_top_tb
`default_nettype wire
